// file: rtl/psr_params.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  management register bank. Assumes a 25 MHz device clock and that the
  includer sits in a module or package scope.
*/
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// register indices on the serial management interface
`define PSR_REG_CONTROL     5'h00
`define PSR_REG_STATUS      5'h01
`define PSR_REG_ID_HIGH     5'h02
`define PSR_REG_ID_LOW      5'h03

// this port answers only frames carrying this address
`define PSR_PHY_ADDR        5'h01

// control field
`define PSR_CTL_COLL_BIT    7
`define PSR_CTL_RESET       16'h0000

// status fields
`define PSR_ST_T4_BIT       15
`define PSR_ST_CAP_HI       14
`define PSR_ST_CAP_LO       11
`define PSR_ST_RSV_HI       10
`define PSR_ST_RSV_LO       7
`define PSR_ST_PRE_SUP_BIT  6
`define PSR_ST_AN_DONE_BIT  5
`define PSR_ST_RFAULT_BIT   4
`define PSR_ST_AN_ABLE_BIT  3
`define PSR_ST_LINK_BIT     2
`define PSR_ST_JABBER_BIT   1
`define PSR_ST_EXT_BIT      0

// identity values; all three values are arbitrary
`define PSR_ORG_ID          24'h5A3C81
`define PSR_MODEL_NUM       6'h15
`define PSR_MODEL_REV       4'h2

// frame constants
`define PSR_PRE_LEN         6'h20
`define PSR_OP_READ         2'h2
`define PSR_OP_WRITE        2'h1

// collision test timing, worst case at the 100 Mb/s bit time
`define PSR_CLK_NS          40
`define PSR_BIT_NS          10
`define PSR_COL_ON_BITS     512
`define PSR_COL_OFF_BITS    4
`define PSR_COL_ON_MAX_CYC  ((`PSR_COL_ON_BITS * `PSR_BIT_NS) / `PSR_CLK_NS)
`define PSR_COL_OFF_MAX_CYC ((`PSR_COL_OFF_BITS * `PSR_BIT_NS) / `PSR_CLK_NS)

`endif

// file: rtl/psr_pkg.sv
/*
  Types of the management register bank: state encodings and the packed
  state records of each module. Assumes psr_params.svh for all numbers.
*/
package psr_pkg;

  typedef enum logic [2:0] {
    PSR_IDLE  = 3'b000,
    PSR_START = 3'b001,
    PSR_OP    = 3'b010,
    PSR_ADDR  = 3'b011,
    PSR_TA    = 3'b100,
    PSR_DATA  = 3'b101
  } psr_fsm_t;

  // live indications from the transceiver core
  typedef struct packed {
    logic an_done;
    logic rfault;
    logic link_ok;
    logic jabber;
    logic speed_100;
  } psr_phy_stat_t;

  // bit 1 is the management clock, bit 0 the data line
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic       mdc_prev;
    logic       rise;
    logic       bit_val;
  } psr_sync_t;

  // high_lat[1] remote fault, high_lat[0] jabber
  typedef struct packed {
    logic [1:0] high_lat;
    logic       link_lat;
  } psr_lat_t;

  typedef struct packed {
    psr_fsm_t    fsm;
    logic [3:0]  cnt;
    logic [5:0]  pre_cnt;
    logic        pre_ok;
    logic        is_read;
    logic        op_msb;
    logic [9:0]  addr;
    logic [15:0] sr;
    logic        coll_test;
    logic        mdio_o;
    logic        mdio_oe;
    logic        col;
    logic        status_rd;
  } psr_state_t;

endpackage : psr_pkg

// file: rtl/psr_sync.sv
/*
  Brings the management clock and data pins into the device clock domain
  and marks each rising edge of the management clock with the data bit
  sampled with it. Assumes mclk is well above twice the management clock.
*/
`include "psr_params.svh"

module psr_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic mdc,
  input  wire logic mdio_i,
  output logic      rise,
  output logic      bit_val
);

  psr_pkg::psr_sync_t q;
  psr_pkg::psr_sync_t d;
  logic [1:0]         pins;

  assign pins = {mdc, mdio_i};

  // first stage feeds only the second stage
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_comb begin
      d.meta[i] = pins[i];
      d.sync[i] = q.meta[i];
    end
  end

  always_comb begin
    d.mdc_prev = q.sync[1];
    d.rise     = q.sync[1] & ~q.mdc_prev;
    d.bit_val  = q.sync[0];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise    = q.rise;
  assign bit_val = q.bit_val;

endmodule : psr_sync

// file: rtl/psr_latch.sv
/*
  Latched status flags: remote fault and jabber latch high, link latches
  low. A clear pulse follows a completed status read. Assumes all inputs
  are in the mclk domain.
*/
`include "psr_params.svh"

module psr_latch (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire psr_pkg::psr_phy_stat_t stat,
  input  wire logic                   clr,
  output psr_pkg::psr_lat_t           lat
);

  psr_pkg::psr_lat_t q;
  psr_pkg::psr_lat_t d;
  logic [1:0]        set;

  // jabber is meaningful only at 10 Mb/s
  assign set = {stat.rfault, stat.jabber & ~stat.speed_100};

  // set wins over a clear in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_lh
    always_comb begin
      d.high_lat[i] = set[i] | (q.high_lat[i] & ~clr);
    end
  end

  // any failure drops it; only a read with good link raises it
  always_comb begin
    d.link_lat = stat.link_ok & (q.link_lat | clr);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lat = q;

endmodule : psr_latch

// file: rtl/psr_regs.sv
/*
  Management register bank of a 10/100 transceiver: serial management
  frame engine, control register with collision test, status register
  with fixed capabilities and latched flags, and the 32-bit identifier.
  Assumes tx_en and the core status inputs are on mclk; mdc and mdio_i
  arrive from outside and are synchronised.
*/
`include "psr_params.svh"

module psr_regs (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic mdc,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe,
  input  wire logic tx_en,
  output logic      col,
  output logic      coll_test_en,
  input  wire logic an_done,
  input  wire logic rfault,
  input  wire logic link_ok,
  input  wire logic jabber,
  input  wire logic speed_100
);

  // a literal cannot be part-selected, so the identity lives in a named constant
  localparam logic [23:0] ORG_ID = `PSR_ORG_ID;

  psr_pkg::psr_state_t    q;
  psr_pkg::psr_state_t    d;
  psr_pkg::psr_phy_stat_t stat;
  psr_pkg::psr_lat_t      lat;
  logic                   rise;
  logic                   bit_val;
  logic [9:0]             addr_n;
  logic [15:0]            rd_word;
  logic [15:0]            st_word;
  logic [15:0]            ctl_word;
  logic [15:0]            wr_word;
  logic [1:0]             op_n;
  logic                   mine_q;

  assign stat = '{an_done:   an_done,
                  rfault:    rfault,
                  link_ok:   link_ok,
                  jabber:    jabber,
                  speed_100: speed_100};

  psr_sync u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mdc     (mdc),
    .mdio_i  (mdio_i),
    .rise    (rise),
    .bit_val (bit_val)
  );

  psr_latch u_latch (
    .mclk  (mclk),
    .rst_n (rst_n),
    .stat  (stat),
    .clr   (q.status_rd),
    .lat   (lat)
  );

  assign addr_n  = {q.addr[8:0], bit_val};
  assign mine_q  = (q.addr[9:5] == `PSR_PHY_ADDR);
  assign op_n    = {q.op_msb, bit_val};
  assign wr_word = {q.sr[14:0], bit_val};

  // only the collision test bit is held; the rest reads zero
  always_comb begin
    ctl_word                    = 16'h0000;
    ctl_word[`PSR_CTL_COLL_BIT] = q.coll_test;
  end

  always_comb begin
    st_word                                = 16'h0000;
    st_word[`PSR_ST_T4_BIT]                = 1'b0;
    st_word[`PSR_ST_CAP_HI:`PSR_ST_CAP_LO] = 4'hF;
    st_word[`PSR_ST_PRE_SUP_BIT]           = 1'b1;
    st_word[`PSR_ST_AN_DONE_BIT]           = an_done;
    st_word[`PSR_ST_RFAULT_BIT]            = lat.high_lat[1];
    st_word[`PSR_ST_AN_ABLE_BIT]           = 1'b1;
    st_word[`PSR_ST_LINK_BIT]              = lat.link_lat;
    st_word[`PSR_ST_JABBER_BIT]            = lat.high_lat[0];
    st_word[`PSR_ST_EXT_BIT]               = 1'b1;
  end

  // identifier: org id bit n sits at index 24-n of the constant
  always_comb begin
    case (addr_n[4:0])
      `PSR_REG_CONTROL: begin
        rd_word = ctl_word;
      end
      `PSR_REG_STATUS: begin
        rd_word = st_word;
      end
      `PSR_REG_ID_HIGH: begin
        rd_word = ORG_ID[21:6];
      end
      `PSR_REG_ID_LOW: begin
        rd_word = {ORG_ID[5:0], `PSR_MODEL_NUM, `PSR_MODEL_REV};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  always_comb begin
    d           = q;
    d.status_rd = 1'b0;
    // tx_en shares this clock, so col follows it by one cycle
    d.col       = q.coll_test & tx_en;
    if (rise) begin
      case (q.fsm)
        psr_pkg::PSR_IDLE: begin
          d.mdio_oe = 1'b0;
          d.mdio_o  = 1'b0;
          if (bit_val) begin
            if (q.pre_cnt != `PSR_PRE_LEN) begin
              d.pre_cnt = q.pre_cnt + 6'h01;
            end
            if (q.pre_cnt == `PSR_PRE_LEN - 6'h01) begin
              d.pre_ok = 1'b1;
            end
          end else begin
            d.pre_cnt = 6'h00;
            // preamble may be skipped once it has been seen
            if (q.pre_ok) begin
              d.fsm = psr_pkg::PSR_START;
            end
          end
        end
        psr_pkg::PSR_START: begin
          if (bit_val) begin
            d.fsm = psr_pkg::PSR_OP;
            d.cnt = 4'h0;
          end else begin
            d.fsm = psr_pkg::PSR_IDLE;
          end
        end
        psr_pkg::PSR_OP: begin
          d.op_msb = bit_val;
          d.cnt    = q.cnt + 4'h1;
          if (q.cnt == 4'h1) begin
            d.cnt = 4'h0;
            if (op_n == `PSR_OP_READ) begin
              d.is_read = 1'b1;
              d.fsm     = psr_pkg::PSR_ADDR;
            end else if (op_n == `PSR_OP_WRITE) begin
              d.is_read = 1'b0;
              d.fsm     = psr_pkg::PSR_ADDR;
            end else begin
              // bad opcode: a fresh preamble is needed
              d.pre_ok = 1'b0;
              d.fsm    = psr_pkg::PSR_IDLE;
            end
          end
        end
        psr_pkg::PSR_ADDR: begin
          d.addr = addr_n;
          d.cnt  = q.cnt + 4'h1;
          if (q.cnt == 4'h9) begin
            d.cnt = 4'h0;
            d.fsm = psr_pkg::PSR_TA;
            // snapshot before any flag may clear
            d.sr  = rd_word;
          end
        end
        psr_pkg::PSR_TA: begin
          d.cnt = q.cnt + 4'h1;
          if (q.is_read) begin
            if (q.cnt == 4'h0) begin
              d.mdio_oe = mine_q;
              d.mdio_o  = 1'b0;
            end else begin
              d.mdio_o = q.sr[15];
              d.sr     = {q.sr[14:0], 1'b0};
              d.cnt    = 4'h0;
              d.fsm    = psr_pkg::PSR_DATA;
            end
          end else if (q.cnt == 4'h0) begin
            if (!bit_val) begin
              d.pre_ok = 1'b0;
              d.fsm    = psr_pkg::PSR_IDLE;
            end
          end else begin
            d.cnt = 4'h0;
            if (bit_val) begin
              d.pre_ok = 1'b0;
              d.fsm    = psr_pkg::PSR_IDLE;
            end else begin
              d.fsm = psr_pkg::PSR_DATA;
            end
          end
        end
        psr_pkg::PSR_DATA: begin
          d.cnt = q.cnt + 4'h1;
          if (q.is_read) begin
            d.mdio_o = q.sr[15];
            d.sr     = {q.sr[14:0], 1'b0};
          end else begin
            d.sr = wr_word;
          end
          if (q.cnt == 4'hF) begin
            d.fsm     = psr_pkg::PSR_IDLE;
            d.cnt     = 4'h0;
            d.mdio_oe = 1'b0;
            d.mdio_o  = 1'b0;
            if (q.is_read && mine_q && q.addr[4:0] == `PSR_REG_STATUS) begin
              // flags clear or re-arm only now
              d.status_rd = 1'b1;
            end
            // status and identifier ignore writes
            if (!q.is_read && mine_q && q.addr[4:0] == `PSR_REG_CONTROL) begin
              d.coll_test = wr_word[`PSR_CTL_COLL_BIT];
            end
          end
        end
        default: begin
          d.fsm     = psr_pkg::PSR_IDLE;
          d.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q         <= '0;
      q.fsm     <= psr_pkg::PSR_IDLE;
      q.pre_cnt <= 6'h00;
      q.pre_ok  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign mdio_o       = q.mdio_o;
  assign mdio_oe      = q.mdio_oe;
  assign col          = q.col;
  assign coll_test_en = q.coll_test;

endmodule : psr_regs

// file: dv/psr_regs_monitor.sv
/*
  Checker of the register bank's pins: collision test timing, reset
  quiet state and the shape of the device's drive on the data line.
  Assumes it is bound to psr_regs and sees only its ports.
*/
module psr_regs_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic tx_en,
  input wire logic col,
  input wire logic coll_test_en
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] idle_q;
  logic [7:0] oe_q;
  logic       mdc_q;

  // idle_q counts cycles since the last management clock change
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mdc_q  <= 1'b0;
      idle_q <= 8'h00;
      oe_q   <= 8'h00;
    end else begin
      mdc_q  <= mdc;
      idle_q <= (mdc != mdc_q) ? 8'h00 : ((idle_q == 8'hFF) ? idle_q : idle_q + 8'h01);
      oe_q   <= mdio_oe ? oe_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence tx_held_s;
    coll_test_en && tx_en ##1 coll_test_en && tx_en;
  endsequence

  col_on_a: assert property (tx_held_s |-> col)
    else $error("col low while collision test and tx_en held");
  col_fast_a: assert property (coll_test_en && $rose(tx_en) |=> col)
    else $error("col late after tx_en rise");
  col_off_a: assert property ($fell(tx_en) |-> ##1 !col)
    else $error("col late after tx_en fall");
  col_gate_a: assert property (!coll_test_en |=> !col)
    else $error("col raised without collision test");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !col && !mdio_oe && !coll_test_en)
    else $error("outputs active after reset edge");
  ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not zero");
  oe_len_a: assert property (oe_q <= 8'h8C)
    else $error("data line driven too long");
  idle_quiet_a: assert property (idle_q >= 8'h20 |-> !mdio_oe)
    else $error("data line driven with no frame");
  ctl_stable_a: assert property (idle_q >= 8'h20 |-> $stable(coll_test_en))
    else $error("control bit changed with no frame");
endmodule : psr_regs_monitor

bind psr_regs psr_regs_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_o(mdio_o),
  .mdio_oe(mdio_oe), .tx_en(tx_en), .col(col), .coll_test_en(coll_test_en));

// file: dv/psr_mgmt_host.sv
/*
  Station management controller model: makes the management clock and
  the host side of the data line. Assumes the bench resolves the shared
  data wire with a pull-up and runs mclk at 40 ns.
*/
module psr_mgmt_host (
  input  wire logic mclk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      host_o,
  output logic      host_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mdc     = 1'b0;
    host_o  = 1'b1;
    host_oe = 1'b0;
  end

  // 320 ns bit; data set while mdc low, line sampled at the rise
  task automatic bit_io(input logic drv, input logic b, output logic s);
    @(negedge mclk);
    mdc     = 1'b0;
    host_oe = drv;
    host_o  = b;
    repeat (4) @(negedge mclk);
    s   = mdio;
    mdc = 1'b1;
    repeat (3) @(negedge mclk);
  endtask : bit_io

  task automatic xfer(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        rdop;
    logic        s;
    hdr  = {2'b01, op, pa, ra};
    rdop = (op == `PSR_OP_READ);
    if (pre) for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], s);
    bit_io(!rdop, 1'b1, s);
    bit_io(!rdop, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_io(!rdop, wd[i], s);
      rd[i] = s;
    end
    // clock stands still low between frames
    @(negedge mclk);
    mdc     = 1'b0;
    host_oe = 1'b0;
    repeat (8) @(negedge mclk);
  endtask : xfer
endmodule : psr_mgmt_host

// file: dv/tb.sv
/*
  Self-checking bench of the management register bank: frames through
  the host model, core status pins and collision test. Assumes the
  design, checker and host model are compiled before it.
*/
`include "psr_params.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [23:0] ORG = `PSR_ORG_ID;

  logic                   mclk, rst_n, mdc, mdio, mdio_o, mdio_oe, host_o, host_oe;
  logic                   tx_en, col, coll_test_en;
  psr_pkg::psr_phy_stat_t st;
  logic [15:0]            rd;
  int                     failures, total_checks;

  assign mdio = mdio_oe ? mdio_o : (host_oe ? host_o : 1'b1);

  psr_regs dut_u (
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .tx_en(tx_en), .col(col), .coll_test_en(coll_test_en),
    .an_done(st.an_done), .rfault(st.rfault), .link_ok(st.link_ok),
    .jabber(st.jabber), .speed_100(st.speed_100)
  );

  psr_mgmt_host host_u (.mclk(mclk), .mdio(mdio), .mdc(mdc), .host_o(host_o), .host_oe(host_oe));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic rd_chk(input logic pre, input logic [4:0] ra, input logic [15:0] exp);
    host_u.xfer(pre, `PSR_OP_READ, `PSR_PHY_ADDR, ra, 16'h0000, rd);
    `CHK(rd, exp)
  endtask : rd_chk

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    host_u.xfer(1'b0, `PSR_OP_WRITE, `PSR_PHY_ADDR, ra, wd, rd);
  endtask : wr

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    #1_000_000;
    failures++;
    end_of_test();
  end

  initial begin
    rst_n      = 1'b0;
    tx_en      = 1'b0;
    st         = '0;
    st.link_ok = 1'b1;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd_chk(1'b1, `PSR_REG_ID_HIGH, ORG[21:6]);
    rd_chk(1'b0, `PSR_REG_ID_LOW, {ORG[5:0], `PSR_MODEL_NUM, `PSR_MODEL_REV});
    wr(`PSR_REG_ID_HIGH, 16'h0000);
    rd_chk(1'b0, `PSR_REG_ID_HIGH, ORG[21:6]);
    $display("test ident done");
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h7849);
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h784D);
    wr(`PSR_REG_STATUS, 16'h0000);
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h784D);
    $display("test status done");
    // all three events in one cycle, link back up at once
    st.an_done = 1'b1;
    @(negedge mclk);
    st.rfault  = 1'b1;
    st.jabber  = 1'b1;
    st.link_ok = 1'b0;
    @(negedge mclk);
    st.rfault  = 1'b0;
    st.jabber  = 1'b0;
    st.link_ok = 1'b1;
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h787B);
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h786D);
    st.speed_100 = 1'b1;
    @(negedge mclk);
    st.jabber = 1'b1;
    @(negedge mclk);
    st.jabber = 1'b0;
    rd_chk(1'b0, `PSR_REG_STATUS, 16'h786D);
    $display("test latches done");
    wr(`PSR_REG_CONTROL, 16'hFFFF);
    `CHK(coll_test_en, 1'b1)
    rd_chk(1'b0, `PSR_REG_CONTROL, 16'h0080);
    tx_en = 1'b1;
    @(negedge mclk);
    `CHK(col, 1'b1)
    repeat (3) @(negedge mclk);
    tx_en = 1'b0;
    @(negedge mclk);
    `CHK(col, 1'b0)
    wr(`PSR_REG_CONTROL, 16'h0000);
    tx_en = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK(col, 1'b0)
    tx_en = 1'b0;
    $display("test collision done");
    host_u.xfer(1'b0, 2'h0, `PSR_PHY_ADDR, `PSR_REG_STATUS, 16'h0000, rd);
    rd_chk(1'b0, `PSR_REG_ID_HIGH, 16'hFFFF);
    rd_chk(1'b1, `PSR_REG_ID_HIGH, ORG[21:6]);
    host_u.xfer(1'b0, `PSR_OP_READ, 5'h02, `PSR_REG_ID_HIGH, 16'h0000, rd);
    `CHK(rd, 16'hFFFF)
    $display("test refusal done");
    end_of_test();
  end
endmodule : tb
